// ===== verilog/dpc_host.sv
// Controller driving DDR2 CKE and commands for power-down and frequency change
`timescale 1ns/10ps
module dpc_host
  import dpc_pkg::*;
#(
  parameter int STAY_CLKS = MAX_REFI_STAY * REFI_CLKS,
  parameter int RELOCK_CLKS = DLL_LOCK_CLKS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        pdReq,
  input  wire logic        srReq,
  input  wire logic        freqReq,
  input  wire logic        freqDone,
  input  wire logic        wakeReq,
  input  wire logic        banksIdle,
  input  wire logic        burstBusy,
  input  wire logic        dllLocked,
  output logic             cke,
  output logic             csN,
  output logic             rasN,
  output logic             casN,
  output logic             weN,
  output logic [1:0]       ba,
  output logic [12:0]      addr,
  output logic             odt,
  output logic             freqGrant,
  output logic             busy,
  output logic             ready
);
  typedef enum logic [6:0] {
    S_RUN    = 7'h01,
    S_PD     = 7'h02,
    S_SR     = 7'h04,
    S_FREQ   = 7'h08,
    S_EXIT   = 7'h10,
    S_DLLRST = 7'h20,
    S_RELOCK = 7'h40
  } dpc_state_t;

  dpc_state_t state_q;
  logic       load;
  logic [15:0] loadVal;
  logic       done;
  logic       dllStale_q;
  logic       freqChg_q;
  logic       pdPre_q;
  logic [31:0] stay_q;

  // ==========================================================
  // Timers
  dpc_counter #(.W(16)) uTimer (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (load),
    .loadVal (loadVal),
    .done    (done)
  );

  wire logic enterOk = !burstBusy && done;
  wire logic stayOver = (stay_q >= 32'(STAY_CLKS));

  always_comb begin
    load = 1'b0;
    loadVal = '0;
    unique case (state_q)
      S_RUN: begin
        if (enterOk && banksIdle && (srReq || pdReq || freqReq)) begin
          load = 1'b1;
          loadVal = 16'(CKE_MIN_CLKS);
        end else if (enterOk && pdReq) begin
          load = 1'b1;
          loadVal = 16'(CKE_MIN_CLKS);
        end
      end
      S_PD, S_SR, S_FREQ: begin
        if (done && (wakeReq || stayOver) && !(state_q == S_FREQ && !freqDone)) begin
          load = 1'b1;
          loadVal = (state_q == S_SR) ? 16'(XSRD_CLKS) : 16'(TXP_CLKS);
        end
      end
      S_EXIT: begin
        if (done && (dllStale_q || freqChg_q)) begin
          load = 1'b1;
          loadVal = 16'(RELOCK_CLKS);
        end
      end
      S_DLLRST: begin
        load = 1'b1;
        loadVal = 16'(RELOCK_CLKS);
      end
      S_RELOCK: begin
        load = 1'b0;
        loadVal = '0;
      end
    endcase
  end

  // ==========================================================
  // State
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_RUN;
    end else begin
      unique case (state_q)
        S_RUN: begin
          if (enterOk && banksIdle && srReq) begin
            state_q <= S_SR;
          end else if (enterOk && banksIdle && freqReq) begin
            state_q <= S_FREQ;
          end else if (enterOk && pdReq) begin
            state_q <= S_PD;
          end
        end
        S_PD, S_SR, S_FREQ: begin
          if (load) begin
            state_q <= S_EXIT;
          end
        end
        S_EXIT: begin
          if (done) begin
            state_q <= (dllStale_q || freqChg_q) ? S_DLLRST : S_RUN;
          end
        end
        S_DLLRST: state_q <= S_RELOCK;
        S_RELOCK: begin
          if (done) begin
            state_q <= S_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Bookkeeping
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dllStale_q <= 1'b0;
      freqChg_q <= 1'b0;
      pdPre_q <= 1'b0;
    end else if (state_q == S_RUN && enterOk && (pdReq || srReq || freqReq)) begin
      dllStale_q <= !dllLocked;
      freqChg_q <= banksIdle && freqReq && !srReq;
      pdPre_q <= banksIdle;
    end else if (state_q == S_RELOCK && done) begin
      dllStale_q <= 1'b0;
      freqChg_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stay_q <= '0;
    end else if (state_q == S_RUN) begin
      stay_q <= '0;
    end else if (!stayOver) begin
      stay_q <= stay_q + 32'h1;
    end
  end

  // ==========================================================
  // Pins
  wire logic down = (state_q == S_PD) || (state_q == S_SR) || (state_q == S_FREQ);
  wire logic entering = (state_q == S_RUN) && load;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cke <= 1'b1;
      {csN, rasN, casN, weN} <= CMD_DESEL;
      ba <= '0;
      addr <= '0;
      odt <= 1'b0;
      freqGrant <= 1'b0;
    end else begin
      cke <= !(entering || (down && !load));
      odt <= 1'b0;
      freqGrant <= (state_q == S_FREQ) && pdPre_q && done && !load;
      ba <= '0;
      addr <= '0;
      if (entering && banksIdle && srReq) begin
        {csN, rasN, casN, weN} <= CMD_REF;
      end else if (state_q == S_DLLRST) begin
        {csN, rasN, casN, weN} <= CMD_MRS;
        ba <= BA_MR;
        addr <= MR_DLL_RESET;
      end else begin
        {csN, rasN, casN, weN} <= CMD_NOP;
      end
    end
  end

  assign busy = (state_q != S_RUN) || !done;
  assign ready = (state_q == S_RUN) && done;
endmodule : dpc_host

// ===== include/dpc_pkg.sv
// Constants for the DDR2 power-down command sequencer
package dpc_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CKE_MIN_CLKS = 3;
  localparam int FREQ_WAIT_CLKS = 2;
  localparam int XSRD_CLKS = 200;
  localparam int TXP_NS = 8;
  localparam int TXP_CLKS = (TXP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFI_NS = 7800;
  localparam int REFI_CLKS = (REFI_NS * 1000) / CLK_PERIOD_PS;
  localparam int MAX_REFI_STAY = 9;
  localparam int DLL_LOCK_CLKS = 200;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'hf;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [12:0] MR_DLL_RESET = 13'h0100;
endpackage : dpc_pkg

// ===== verilog/dpc_counter.sv
// Down counter that holds done high once it reaches zero
`timescale 1ns/10ps
module dpc_counter
  import dpc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              done
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= loadVal;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign done = (cnt_q == '0);
endmodule : dpc_counter

// ===== bench/dpc_host_assertions.sv
// Port assertions for the power-down controller
`timescale 1ns/10ps
module dpc_host_assertions
  import dpc_pkg::*;
#(
  parameter int STAY_CLKS   = 50,
  parameter int RELOCK_CLKS = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic burstBusy,
  input wire logic banksIdle,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic odt,
  input wire logic freqGrant
);
  // ==========================================================
  // Checks
  wire nopCmd = csN || {rasN, casN, weN} == 3'h7;
  wire refCmd = !csN && {rasN, casN, weN} == 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_low_held: assert property ($fell(cke) |=> !cke [*2]) else $error("cke low too short");
  a_high_held: assert property ($rose(cke) |=> cke [*2]) else $error("cke high too short");
  a_entry_nop: assert property ($fell(cke) |-> nopCmd || refCmd) else $error("bad entry command");
  a_exit_wait: assert property ($rose(cke) |-> nopCmd [*2]) else $error("command inside exit latency");
  a_no_burst: assert property ($fell(cke) |-> !$past(burstBusy)) else $error("cke low during burst");
  a_sr_idle: assert property ($fell(cke) && refCmd |-> $past(banksIdle)) else $error("self refresh busy");
  a_odt_off: assert property (!odt) else $error("odt driven on");
  a_grant_wait: assert property (freqGrant |-> !cke && !$past(cke) && !$past(cke, 2)) else $error("early grant");
endmodule : dpc_host_assertions
bind dpc_host dpc_host_assertions #(.STAY_CLKS(STAY_CLKS), .RELOCK_CLKS(RELOCK_CLKS)) i_dpc_host_assertions (
  .clk(clk), .reset_n(reset_n), .burstBusy(burstBusy), .banksIdle(banksIdle), .cke(cke), .csN(csN),
  .rasN(rasN), .casN(casN), .weN(weN), .odt(odt), .freqGrant(freqGrant));

// ===== bench/dpc_ddr_model.sv
// Behavioural DDR2 device seen by the power-down controller
`timescale 1ns/10ps
module dpc_ddr_model
  import dpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        cke,
  input  wire logic [3:0]  cmd,
  input  wire logic [1:0]  ba,
  input  wire logic [12:0] addr,
  output logic             pdn = 1'b0,
  output logic             sref = 1'b0,
  output logic             dllRst = 1'b0
);
  logic ckePrev = 1'b1;
  // ==========================================================
  // Command decode and power states
  always_ff @(posedge clk) begin
    ckePrev <= cke;
    if (ckePrev && !cke && (cmd[3] || cmd == CMD_NOP)) pdn <= 1'b1;
    if (ckePrev && !cke && cmd == CMD_REF) sref <= 1'b1;
    if (!ckePrev && cke) begin
      pdn <= 1'b0;
      sref <= 1'b0;
    end
    if (ckePrev && !cke) dllRst <= 1'b0;
    if (cke && cmd == CMD_MRS && ba == BA_MR && addr === MR_DLL_RESET) dllRst <= 1'b1;
  end
endmodule : dpc_ddr_model

// ===== bench/testbench.sv
// Self-checking bench for the power-down controller
`timescale 1ns/10ps
module testbench;
  import dpc_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, freqDone = 1'b0, wakeReq = 1'b0;
  logic        banksIdle = 1'b1, burstBusy = 1'b0, dllLocked = 1'b1;
  logic [2:0]  req = 3'h0;
  logic        cke, csN, rasN, casN, weN, odt, freqGrant, ready, busy, pdn, sref, dllRst;
  logic [1:0]  ba;
  logic [12:0] addr;
  int          mismatches = 0;
  int          check_count = 0;
  // ==========================================================
  // Harness and scenarios
  always #2 clk = ~clk;
  dpc_host #(.STAY_CLKS(50), .RELOCK_CLKS(10)) i_dpc_host (.clk(clk), .reset_n(reset_n), .pdReq(req[0]),
    .freqReq(req[1]), .srReq(req[2]), .freqDone(freqDone), .wakeReq(wakeReq), .banksIdle(banksIdle),
    .burstBusy(burstBusy), .dllLocked(dllLocked), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .ba(ba), .addr(addr), .odt(odt), .freqGrant(freqGrant), .busy(busy), .ready(ready));
  dpc_ddr_model i_dpc_ddr_model (.clk(clk), .cke(cke), .cmd({csN, rasN, casN, weN}), .ba(ba), .addr(addr),
    .pdn(pdn), .sref(sref), .dllRst(dllRst));
  task report_and_stop;
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task waitSel(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && (s == 0 ? cke : s == 1 ? ready : freqGrant) !== v; i++) step(1);
    chk(i < lim, "wait ran out");
  endtask : waitSel
  task enter(input logic [2:0] r);
    @(posedge clk) req <= r;
    waitSel(0, 1'b0, 10);
    @(posedge clk) req <= 3'h0;
    #1;
  endtask : enter
  task wake(input int lim);
    @(posedge clk) wakeReq <= 1'b1;
    waitSel(0, 1'b1, 10);
    @(posedge clk) wakeReq <= 1'b0;
    #1 waitSel(1, 1'b1, lim);
  endtask : wake
  task t_refuse;
    @(posedge clk) burstBusy <= 1'b1;
    @(posedge clk) req <= 3'h1;
    step(8);
    chk(cke, "entry during burst");
    @(posedge clk) burstBusy <= 1'b0;
    banksIdle <= 1'b0;
    req <= 3'h4;
    step(8);
    chk(cke, "self refresh with open bank");
    @(posedge clk) req <= 3'h0;
    banksIdle <= 1'b1;
  endtask : t_refuse
  task t_pd;
    enter(3'h1);
    chk(pdn && busy, "no power-down entry");
    step(3);
    chk(!cke, "cke rose early");
    wake(20);
    chk(!pdn, "no power-down exit");
    chk(!dllRst, "needless DLL reset");
  endtask : t_pd
  task t_sr;
    enter(3'h4);
    chk(sref, "no self refresh");
    step(3);
    @(posedge clk) wakeReq <= 1'b1;
    waitSel(0, 1'b1, 10);
    @(posedge clk) wakeReq <= 1'b0;
    step(150);
    chk(!sref && !ready, "early ready after self refresh");
    waitSel(1, 1'b1, 100);
  endtask : t_sr
  task t_freq;
    @(posedge clk) req <= 3'h2;
    waitSel(2, 1'b1, 20);
    @(posedge clk) req <= 3'h0;
    wakeReq <= 1'b1;
    step(4);
    chk(!cke && freqGrant, "exit before new clock");
    @(posedge clk) freqDone <= 1'b1;
    wake(40);
    chk(dllRst, "no DLL reset");
    @(posedge clk) freqDone <= 1'b0;
    #1;
  endtask : t_freq
  task t_stay;
    @(posedge clk) banksIdle <= 1'b0;
    dllLocked <= 1'b0;
    enter(3'h1);
    chk(pdn, "no active power-down");
    step(40);
    chk(!cke, "stay ended early");
    waitSel(0, 1'b1, 30);
    waitSel(1, 1'b1, 30);
    chk(dllRst, "no DLL reset after unlocked entry");
  endtask : t_stay
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_refuse;
    t_pd;
    t_sr;
    t_freq;
    t_stay;
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule : testbench
